// file: logic/clock_reset_pkg.sv
// Shared constants and types for the clock monitor and reset generator
package clock_reset_pkg;
   // Register word addresses on the serial register port
   localparam logic [9:0] ADDR_MULT_CFG = 10'h1C6;
   localparam logic [9:0] ADDR_BACKUP_STATUS = 10'h1C7;
   localparam logic [9:0] ADDR_GRST_LOW = 10'h1D0;
   localparam logic [9:0] ADDR_GRST_HIGH = 10'h1D1;
   localparam logic [9:0] ADDR_SERIAL_ERROR = 10'h1D3;
   // Field positions
   localparam int FACTOR_BIT = 0;
   localparam int SPREAD_OFF_BIT = 1;
   localparam int BACKUP_IN_USE_BIT = 0;
   localparam int DRV_OFF_BIT = 1;
   localparam int SWITCH_BACK_BIT = 2;
   localparam int CLK_ABSENT_BIT = 3;
   localparam int SERIAL_ERR_BIT = 0;
   // Reset values
   localparam logic [1:0] MULT_CFG_RESET = 2'h1;
   localparam logic [15:0] GRST_LOW_CODE = 16'hF473;
   localparam logic [15:0] GRST_HIGH_CODE = 16'h57A1;
   localparam logic [3:0] GRST_CYCLES = 4'h8;
   // Monitor window limits
   localparam logic [7:0] HI24 = 8'hA5;
   localparam logic [7:0] LO24 = 8'h7D;
   localparam logic [7:0] HI12 = 8'h54;
   localparam logic [7:0] LO12 = 8'h3D;
   localparam logic [2:0] WINDOW_PERIODS = 3'h6;
   // Timing
   localparam int CLK_MHZ = 100;
   localparam int IDLE_US = 100;
   localparam int SUSPEND_US = 250;
   localparam int RELOCK_US = 100;
   localparam int IDLE_CYC = IDLE_US * CLK_MHZ;
   localparam int SUSPEND_CYC = SUSPEND_US * CLK_MHZ;
   localparam int RELOCK_CYC = RELOCK_US * CLK_MHZ;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_USE_EXT = 3'b001,
      ST_LOCK_BACKUP = 3'b010,
      ST_USE_BACKUP = 3'b011,
      ST_SWITCH_BACK = 3'b100
   } clk_state_t;

   // Register read and write strobes with address and data
   typedef struct packed {
      logic wr;
      logic rd;
      logic [9:0] addr;
      logic [15:0] wdata;
   } reg_req_t;

   // Reset domain outputs, active low
   typedef struct packed {
      logic monitor_n;
      logic cipher_n;
      logic serial_n;
      logic main_n;
   } resets_t;
endpackage

// file: logic/clock_monitor_and_reset_gen.sv
// Clock manager with frequency monitor and four-domain reset generator
`timescale 1ns/100ps
module clock_monitor_and_reset_gen
   import clock_reset_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic reset_pin_n,
   input wire logic power_on_reset_n,
   input wire logic backup_ref,
   input wire logic loop_out_clk,
   input wire logic loop_lock,
   input wire logic chip_select_n,
   input wire reg_req_t req,
   output logic [15:0] rdata,
   output logic ref_sel_backup,
   output logic factor_24,
   output logic spread_on,
   output logic sys_clk_enable,
   output logic backup_ref_in_use,
   output logic clock_absent,
   output logic interrupt_pin_n,
   output logic core_irq,
   output logic drivers_off,
   output logic serial_abort,
   output resets_t resets_n
);
   ////////////////////////////////////////////////////////////////////
   // Reset release and input synchronisers
   logic rst_s1_ff, rst_ff;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rst_s1_ff <= 1'b0;
         rst_ff <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_ff <= rst_s1_ff;
      end
   end

   // Two-stage capture of everything that comes from other domains
   logic [5:0] sync1_ff, sync2_ff, prev_ff;
   wire logic [5:0] raw_in = {chip_select_n, loop_lock, loop_out_clk, backup_ref,
                              power_on_reset_n, reset_pin_n};
   always_ff @(posedge clock or negedge rst_ff) begin
      if (!rst_ff) begin
         sync1_ff <= 6'h3F;
         sync2_ff <= 6'h3F;
         prev_ff <= 6'h3F;
      end else if (clk_en) begin
         sync1_ff <= raw_in;
         sync2_ff <= sync1_ff;
         prev_ff <= sync2_ff;
      end
   end
   wire logic pin_n = sync2_ff[0];
   wire logic por_n = sync2_ff[1];
   wire logic bref_rise = sync2_ff[2] & ~prev_ff[2];
   wire logic out_rise = sync2_ff[3] & ~prev_ff[3];
   wire logic lock_s = sync2_ff[4];
   wire logic cs_idle = sync2_ff[5];

   ////////////////////////////////////////////////////////////////////
   // Register decode
   wire logic wr_cfg = req.wr && req.addr == ADDR_MULT_CFG;
   wire logic wr_stat = req.wr && req.addr == ADDR_BACKUP_STATUS;
   wire logic wr_glo = req.wr && req.addr == ADDR_GRST_LOW;
   wire logic wr_ghi = req.wr && req.addr == ADDR_GRST_HIGH;
   wire logic rd_err = req.rd && req.addr == ADDR_SERIAL_ERROR;

   logic [1:0] cfg_ff;
   logic drv_off_ff, switch_req_ff;
   logic [15:0] glo_ff, ghi_ff;
   logic [3:0] grst_cnt_ff;
   logic serial_err_ff;
   logic main_rst_n;
   wire logic codes_ok = glo_ff == GRST_LOW_CODE && ghi_ff == GRST_HIGH_CODE;
   wire logic grst_active = grst_cnt_ff != 4'h0;

   // Configuration and status control bits
   always_ff @(posedge clock or negedge main_rst_n) begin
      if (!main_rst_n) begin
         cfg_ff <= MULT_CFG_RESET;
         drv_off_ff <= 1'b0;
      end else if (clk_en) begin
         if (wr_cfg) cfg_ff <= req.wdata[1:0];
         if (wr_stat) drv_off_ff <= req.wdata[DRV_OFF_BIT];
      end
   end
   assign spread_on = ~cfg_ff[SPREAD_OFF_BIT];

   // Global reset code slices; held during the global reset they cause, cleared on its last cycle
   always_ff @(posedge clock or negedge rst_ff) begin
      if (!rst_ff) begin
         glo_ff <= 16'h0000;
         ghi_ff <= 16'h0000;
         grst_cnt_ff <= 4'h0;
      end else if (clk_en) begin
         if (grst_cnt_ff == 4'h1) begin
            glo_ff <= 16'h0000;
            ghi_ff <= 16'h0000;
         end else if (!grst_active) begin
            if (wr_glo) glo_ff <= req.wdata;
            if (wr_ghi) ghi_ff <= req.wdata;
         end
         if (grst_active) grst_cnt_ff <= grst_cnt_ff - 4'h1;
         else if (codes_ok) grst_cnt_ff <= GRST_CYCLES;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Frequency monitor: window of backup periods
   logic [2:0] per_cnt_ff;
   logic [7:0] win_cnt_ff;
   logic factor_ff, bad_ff, valid_ff;
   wire logic win_end = bref_rise && per_cnt_ff == WINDOW_PERIODS - 3'h1;
   wire logic [7:0] hi_lim = factor_ff ? HI24 : HI12;
   wire logic [7:0] lo_lim = factor_ff ? LO24 : LO12;
   wire logic win_bad = win_cnt_ff > hi_lim || win_cnt_ff < lo_lim;
   assign factor_24 = factor_ff;

   always_ff @(posedge clock or negedge rst_ff) begin
      if (!rst_ff) begin
         per_cnt_ff <= 3'h0;
         win_cnt_ff <= 8'h00;
         factor_ff <= MULT_CFG_RESET[FACTOR_BIT];
         bad_ff <= 1'b0;
      end else if (clk_en) begin
         if (out_rise && win_cnt_ff != 8'hFF) win_cnt_ff <= win_cnt_ff + 8'h01;
         if (bref_rise) per_cnt_ff <= win_end ? 3'h0 : per_cnt_ff + 3'h1;
         if (win_end) begin
            bad_ff <= win_bad;
            win_cnt_ff <= 8'h00;
            factor_ff <= cfg_ff[FACTOR_BIT];
         end
      end
   end
   // Output valid combines lock and frequency result
   always_ff @(posedge clock or negedge rst_ff) begin
      if (!rst_ff) valid_ff <= 1'b0;
      else if (clk_en) valid_ff <= lock_s & ~bad_ff;
   end

   ////////////////////////////////////////////////////////////////////
   // Clock state machine
   clk_state_t state_ff, nxt_state;
   logic [14:0] tmr_ff;
   logic fell_ff;
   logic monitor_rst_n;
   wire logic tmr_idle_done = tmr_ff >= 15'(IDLE_CYC - 1);
   wire logic tmr_susp_done = tmr_ff >= 15'(SUSPEND_CYC - 1);
   wire logic steady_done = tmr_ff >= 15'(RELOCK_CYC - 1);
   wire logic invalid = bad_ff | ~lock_s;
   // Steady path only counts if valid never dropped since the switch
   wire logic relocked = (fell_ff & valid_ff) | (steady_done & ~fell_ff);

   // Next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: if (tmr_idle_done) nxt_state = ST_USE_EXT;
         ST_USE_EXT: if (invalid) nxt_state = ST_LOCK_BACKUP;
         ST_LOCK_BACKUP: if (valid_ff) nxt_state = ST_USE_BACKUP;
         ST_USE_BACKUP: if (switch_req_ff) nxt_state = ST_SWITCH_BACK;
         ST_SWITCH_BACK: begin
            if (relocked) nxt_state = ST_USE_EXT;
            else if (tmr_susp_done && invalid) nxt_state = ST_LOCK_BACKUP;
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   // State, timer and relock edge tracking, on the monitor reset domain
   always_ff @(posedge clock or negedge monitor_rst_n) begin
      if (!monitor_rst_n) begin
         state_ff <= ST_IDLE;
         tmr_ff <= 15'h0000;
         fell_ff <= 1'b0;
         switch_req_ff <= 1'b0;
      end else if (clk_en) begin
         state_ff <= nxt_state;
         if (nxt_state != state_ff) tmr_ff <= 15'h0000;
         else if (tmr_ff != 15'h7FFF) tmr_ff <= tmr_ff + 15'h0001;
         if (state_ff != ST_SWITCH_BACK) fell_ff <= 1'b0;
         else if (!valid_ff) fell_ff <= 1'b1;
         // Request honoured only from use-backup; set beats clear
         if (wr_stat && req.wdata[SWITCH_BACK_BIT] && state_ff == ST_USE_BACKUP)
            switch_req_ff <= 1'b1;
         else if (state_ff == ST_SWITCH_BACK) switch_req_ff <= 1'b0;
      end
   end

   // Indications decoded from state; the system clock enable follows lock
   assign ref_sel_backup = state_ff == ST_LOCK_BACKUP || state_ff == ST_USE_BACKUP;
   assign backup_ref_in_use = ref_sel_backup;
   assign clock_absent = state_ff == ST_LOCK_BACKUP || state_ff == ST_SWITCH_BACK;
   assign interrupt_pin_n = ~clock_absent;
   assign core_irq = clock_absent;
   assign drivers_off = drv_off_ff & clock_absent;
   assign sys_clk_enable = lock_s;

   ////////////////////////////////////////////////////////////////////
   // Reset domains; async assert, sync release
   logic [1:0] mon_sr_ff, cip_sr_ff, ser_sr_ff, main_sr_ff;
   wire logic mon_clr_n = pin_n & por_n & resetn;
   wire logic main_clr_n = mon_clr_n & ~grst_active;
   wire logic ser_clr_n = main_clr_n & ~clock_absent;
   wire logic cip_clr_n = por_n & resetn; // Block reset still clears all domains
   // Monitor reset released on a backup reference edge
   always_ff @(posedge clock or negedge mon_clr_n) begin
      if (!mon_clr_n) mon_sr_ff <= 2'h0;
      else if (bref_rise) mon_sr_ff <= {mon_sr_ff[0], 1'b1};
   end
   always_ff @(posedge clock or negedge cip_clr_n) begin
      if (!cip_clr_n) cip_sr_ff <= 2'h0;
      else cip_sr_ff <= {cip_sr_ff[0], 1'b1};
   end
   always_ff @(posedge clock or negedge ser_clr_n) begin
      if (!ser_clr_n) ser_sr_ff <= 2'h0;
      else if (cs_idle) ser_sr_ff <= {ser_sr_ff[0], 1'b1};
   end
   always_ff @(posedge clock or negedge main_clr_n) begin
      if (!main_clr_n) main_sr_ff <= 2'h0;
      else main_sr_ff <= {main_sr_ff[0], 1'b1};
   end
   assign monitor_rst_n = mon_sr_ff[1];
   assign main_rst_n = main_sr_ff[1];
   assign resets_n = '{monitor_n: mon_sr_ff[1], cipher_n: cip_sr_ff[1],
                       serial_n: ser_sr_ff[1], main_n: main_sr_ff[1]};

   ////////////////////////////////////////////////////////////////////
   // Transfer abort and sticky serial error, cleared on read
   assign serial_abort = clock_absent & ~cs_idle;
   always_ff @(posedge clock or negedge rst_ff) begin
      if (!rst_ff) serial_err_ff <= 1'b0;
      else if (clk_en) begin
         if (serial_abort) serial_err_ff <= 1'b1;
         else if (rd_err) serial_err_ff <= 1'b0;
      end
   end

   // Read data, registered
   always_ff @(posedge clock or negedge rst_ff) begin
      if (!rst_ff) rdata <= 16'h0000;
      else if (clk_en && req.rd) begin
         case (req.addr)
            ADDR_MULT_CFG: rdata <= {14'h0000, cfg_ff};
            ADDR_BACKUP_STATUS: rdata <= {12'h000, clock_absent, 1'b0, drv_off_ff,
                                          backup_ref_in_use};
            ADDR_SERIAL_ERROR: rdata <= {15'h0000, serial_err_ff};
            default: rdata <= 16'h0000;
         endcase
      end
   end
endmodule // clock_monitor_and_reset_gen

// file: tb/ref_clock_model.sv
// Reference clock and multiplier loop model for the clock monitor bench
`timescale 1ns/100ps
module ref_clock_model (
   input wire logic ref_sel_backup,
   input wire logic factor_24,
   input wire logic ext_good,
   output logic backup_ref,
   output logic loop_out_clk
);
   //////////////////////////////////////////////////////////////////////
   // Backup reference, 1 MHz, free running like the on-chip oscillator
   initial backup_ref = 1'b0;
   always #500 backup_ref = ~backup_ref;

   // Loop output follows the active factor; a failing pin gives 160 ns
   initial loop_out_clk = 1'b0;
   always begin
      if (ext_good || ref_sel_backup)
         #(factor_24 ? 20.8 : 41.6) loop_out_clk = ~loop_out_clk;
      else
         #80 loop_out_clk = ~loop_out_clk;
   end
endmodule // ref_clock_model

// file: tb/clock_monitor_and_reset_gen_assertions.sv
// Port level checks for the clock monitor and reset generator
`timescale 1ns/100ps
module clock_monitor_and_reset_gen_assertions
   import clock_reset_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic reset_pin_n,
   input wire logic power_on_reset_n,
   input wire logic loop_lock,
   input wire logic chip_select_n,
   input wire reg_req_t req,
   input wire logic ref_sel_backup,
   input wire logic sys_clk_enable,
   input wire logic backup_ref_in_use,
   input wire logic clock_absent,
   input wire logic interrupt_pin_n,
   input wire logic core_irq,
   input wire logic drivers_off,
   input wire logic serial_abort,
   input wire resets_t resets_n
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   //////////////////////////////////////////////////////////////////////
   // Saturating count since release, covers the quiet span after reset
   logic [13:0] up_ff;
   logic [13:0] nxt_up;
   assign nxt_up = (up_ff == 14'h3FFF) ? up_ff : up_ff + 14'h0001;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         up_ff <= 14'h0000;
      else
         up_ff <= nxt_up;
   end
   //////////////////////////////////////////////////////////////////////
   idle_quiet_a: assert property (up_ff < 14'h2328 |-> !clock_absent && !ref_sel_backup)
      else $error("indication raised during idle span");
   irq_follow_a: assert property (core_irq == clock_absent && interrupt_pin_n == !clock_absent)
      else $error("interrupt outputs disagree with clock absent");
   backup_flag_a: assert property (backup_ref_in_use == ref_sel_backup)
      else $error("backup flag disagrees with reference select");
   drv_off_a: assert property (drivers_off |-> clock_absent)
      else $error("drivers off without clock absent");
   abort_a: assert property ((clock_absent && !chip_select_n)[*3] |-> serial_abort)
      else $error("serial access not aborted");
   serial_rst_a: assert property (clock_absent[*3] |-> !resets_n.serial_n)
      else $error("serial reset free while clock absent");
   cipher_keep_a: assert property (resets_n.monitor_n && power_on_reset_n && reset_pin_n
      && !resets_n.main_n |-> resets_n.cipher_n) else $error("cipher reset by global reset");
   grst_len_a: assert property ($fell(resets_n.main_n) && reset_pin_n && power_on_reset_n
      |-> (!resets_n.main_n)[*8]) else $error("global reset shorter than eight clocks");
   switch_back_a: assert property (clk_en && req.wr && req.addr == ADDR_BACKUP_STATUS
      && req.wdata[SWITCH_BACK_BIT] && backup_ref_in_use && !clock_absent
      |-> ##2 clock_absent && !backup_ref_in_use) else $error("switch back not taken");
   lock_gate_a: assert property ((!loop_lock)[*3] |-> !sys_clk_enable)
      else $error("system clock enabled without lock");
endmodule // clock_monitor_and_reset_gen_assertions

// file: tb/clock_monitor_and_reset_gen_tb.sv
// Self-checking bench for the clock monitor and reset generator
`timescale 1ns/100ps
module clock_monitor_and_reset_gen_tb;
   import clock_reset_pkg::*;
   logic clock, resetn, reset_pin_n, power_on_reset_n, chip_select_n, loop_lock, ext_good;
   logic backup_ref, loop_out_clk, ref_sel_backup, factor_24, spread_on, sys_clk_enable;
   logic backup_ref_in_use, clock_absent, interrupt_pin_n, core_irq, drivers_off, serial_abort;
   logic [15:0] rdata;
   logic [7:0] st;
   reg_req_t req;
   resets_t resets_n;
   int n_errors = 0;
   int cmp_count = 0;
   int i;
   // Polled status: resets 3:0, lock 4, factor 5, backup 6, absent 7
   assign st = {clock_absent, backup_ref_in_use, factor_24, sys_clk_enable, resets_n};
   always #5 clock = ~clock;
   clock_monitor_and_reset_gen u_clock_monitor_and_reset_gen (.clock, .resetn, .clk_en(1'b1),
      .reset_pin_n, .power_on_reset_n, .backup_ref, .loop_out_clk, .loop_lock, .chip_select_n,
      .req, .rdata, .ref_sel_backup, .factor_24, .spread_on, .sys_clk_enable, .backup_ref_in_use,
      .clock_absent, .interrupt_pin_n, .core_irq, .drivers_off, .serial_abort, .resets_n);
   ref_clock_model u_ref_clock_model (.ref_sel_backup, .factor_24, .ext_good, .backup_ref,
      .loop_out_clk);
   //////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One-cycle strobes at the falling edge; an idle cycle keeps calls apart
   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      req = '{1'b1, 1'b0, a, d};
      @(negedge clock);
      req = '0;
      @(negedge clock);
   endtask
   task automatic rd(input logic [9:0] a, input logic [15:0] m, input logic [15:0] e);
      req = '{1'b0, 1'b1, a, 16'h0000};
      @(negedge clock);
      req = '0;
      check("rdata", rdata & m, e);
      @(negedge clock);
   endtask
   // Bounded wait on one status bit, then compare it
   task automatic wait_bit(input int b, input logic v, input int lim);
      for (i = 0; i < lim && st[b] !== v; i++)
         @(negedge clock);
      check($sformatf("status bit %0d", b), 16'(st[b]), 16'(v));
   endtask
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////
   // Whole run is near 30k clocks, so 100k clocks means a hang
   initial begin
      #1000000;
      n_errors++;
      wrap_up();
   end
   initial begin
      clock = 1'b0;
      req = '0;
      {resetn, reset_pin_n, power_on_reset_n, chip_select_n, loop_lock, ext_good} = 6'b011111;
      repeat (16) @(negedge clock);
      check("resets", 16'(st[3:0]), 16'h0000);
      check("irq pin", 16'(interrupt_pin_n), 16'h0001);
      check("factor", 16'(factor_24), 16'h0001);
      resetn = 1'b1;
      wait_bit(0, 1'b1, 40);
      wait_bit(1, 1'b1, 40);
      wait_bit(2, 1'b1, 40);
      wait_bit(3, 1'b1, 400);
      rd(ADDR_MULT_CFG, 16'hFFFF, 16'h0001);
      rd(10'h3FF, 16'hFFFF, 16'h0000);
      wr(ADDR_MULT_CFG, 16'h0003);
      check("spread", 16'(spread_on), 16'h0000);
      wr(ADDR_MULT_CFG, 16'h0001);
      check("spread", 16'(spread_on), 16'h0001);
      wr(ADDR_BACKUP_STATUS, 16'h0002);
      repeat (12000) @(negedge clock);
      check("absent", 16'(clock_absent), 16'h0000);
      // Failing pin clock: fall back to the backup reference
      ext_good = 1'b0;
      chip_select_n = 1'b0;
      wait_bit(7, 1'b1, 1500);
      repeat (4) @(negedge clock);
      check("outs", 16'({core_irq, interrupt_pin_n, drivers_off, serial_abort}), 16'hB);
      check("backup", 16'({backup_ref_in_use, resets_n.serial_n}), 16'h2);
      chip_select_n = 1'b1;
      wait_bit(7, 1'b0, 3000);
      check("in use", 16'({backup_ref_in_use, drivers_off}), 16'h2);
      rd(ADDR_SERIAL_ERROR, 16'h0001, 16'h0001);
      rd(ADDR_SERIAL_ERROR, 16'h0001, 16'h0000);
      rd(ADDR_BACKUP_STATUS, 16'h000B, 16'h0003);
      ext_good = 1'b1;
      repeat (3000) @(negedge clock);
      check("no recheck", 16'(backup_ref_in_use), 16'h0001);
      // Switch back is the last access before a long quiet gap
      wr(ADDR_BACKUP_STATUS, 16'h0004);
      @(negedge clock);
      check("switch", 16'({clock_absent, backup_ref_in_use}), 16'h2);
      wait_bit(7, 1'b0, 36000);
      check("ext sel", 16'(ref_sel_backup), 16'h0000);
      wr(ADDR_MULT_CFG, 16'h0000);
      wait_bit(5, 1'b0, 800);
      repeat (2000) @(negedge clock);
      check("absent", 16'(clock_absent), 16'h0000);
      // Global reset: wrong code first, then the right pair
      wr(ADDR_GRST_HIGH, GRST_HIGH_CODE);
      wr(ADDR_GRST_LOW, 16'h1234);
      repeat (20) @(negedge clock);
      check("main", 16'(resets_n.main_n), 16'h0001);
      wr(ADDR_GRST_LOW, GRST_LOW_CODE);
      wait_bit(0, 1'b0, 10);
      for (i = 0; i < 40 && !st[0]; i++)
         @(negedge clock);
      check("grst len", 16'(i >= 8 && i <= 12), 16'h0001);
      rd(ADDR_MULT_CFG, 16'hFFFF, 16'h0001);
      wr(ADDR_GRST_LOW, GRST_LOW_CODE);
      repeat (20) @(negedge clock);
      check("main", 16'(resets_n.main_n), 16'h0001);
      loop_lock = 1'b0;
      wait_bit(4, 1'b0, 10);
      loop_lock = 1'b1;
      wait_bit(4, 1'b1, 10);
      power_on_reset_n = 1'b0;
      repeat (5) @(negedge clock);
      check("por", 16'(st[3:0]), 16'h0000);
      power_on_reset_n = 1'b1;
      wait_bit(2, 1'b1, 20);
      reset_pin_n = 1'b0;
      repeat (5) @(negedge clock);
      check("pin", 16'(st[3:0]), 16'h0004);
      reset_pin_n = 1'b1;
      wait_bit(3, 1'b1, 400);
      wrap_up();
   end
endmodule // clock_monitor_and_reset_gen_tb

bind clock_monitor_and_reset_gen clock_monitor_and_reset_gen_assertions u_chk (.clock, .resetn,
   .clk_en, .reset_pin_n, .power_on_reset_n, .loop_lock, .chip_select_n, .req, .ref_sel_backup,
   .sys_clk_enable, .backup_ref_in_use, .clock_absent, .interrupt_pin_n, .core_irq,
   .drivers_off, .serial_abort, .resets_n);
